// ===== verilog/pulse_counter_continuous_once.sv
// Pulse counter core: gates, limits, loads, outputs and register port
`timescale 1ns/1ps
`default_nettype none
module pulse_counter_continuous_once
  import pulse_counter_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic srst_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Encoder and process pins
  input wire logic count_pulse_i,
  input wire logic count_up_i,
  input wire logic digital_input_i,
  input wire logic sample_instant_i,
  // Process outputs
  output logic first_digital_output_o,
  output logic second_digital_output_o,
  output logic gate_open_o
);

  //============================================================================
  // State
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic prev_pulse;
    logic prev_di;
    logic prev_ti;
    logic sw_bit;
    logic sw_open;
    logic gate;
    logic [1:0] out_plain;
    mode_t mode;
    dir_t dir;
    di_fn_t di_fn;
    logic gate_intr;
    do_fn_t [1:0] do_fn;
    logic [15:0] pulse_len;
    logic [15:0] hyst;
    logic [31:0] count;
    logic [31:0] staged;
    logic [31:0] cmp1;
    logic [31:0] cmp2;
    logic [31:0] hilim;
    logic [31:0] latch;
    logic [31:0] snap_val;
    logic [4:0] snap_sts;
    logic [1:0] do_q;
    logic [1:0][15:0] ptime;
    logic [31:0] rdata;
  } state_t;

  state_t q;
  state_t n;
  logic pulse_ev;
  logic up;
  logic di_lvl;
  logic di_rise;
  logic ti_rise;
  logic hw_ok;
  logic gate_now;
  logic gate_start;
  logic hit;
  logic load_ev;
  logic sw_new;
  logic sw_rise_wr;
  logic [31:0] init_val;
  logic [31:0] cmp_sel;
  logic [31:0] feed_now;

  //============================================================================
  // Functions
  function automatic do_fn_t fn_clean(input logic [2:0] code, input logic first);
    do_fn_t res;
    res = DO_PLAIN;
    if (code <= 3'h3) begin
      res = do_fn_t'(code);
    end else if (code == 3'h4 && first) begin
      res = DO_WINDOW;
    end
    return res;
  endfunction : fn_clean

  function automatic logic out_level(
    input do_fn_t fn,
    input logic cur,
    input logic plain,
    input logic [31:0] cnt,
    input logic [31:0] cmp,
    input logic [31:0] top,
    input logic [15:0] hyst,
    input logic pls
  );
    logic signed [32:0] c;
    logic signed [32:0] m;
    logic signed [32:0] h;
    logic res;
    c = $signed({cnt[31], cnt});
    m = $signed({cmp[31], cmp});
    h = $signed({17'h0_0000, hyst});
    res = plain;
    unique case (fn)
      DO_PLAIN: res = plain;
      DO_GE: res = (c >= m) ? 1'b1 : ((c < m - h) ? 1'b0 : cur);
      DO_LE: res = (c <= m) ? 1'b1 : ((c > m + h) ? 1'b0 : cur);
      DO_PULSE: res = pls;
      DO_WINDOW: res = (c >= m) && (c <= $signed({top[31], top}));
    endcase
    return res;
  endfunction : out_level

  //============================================================================
  // Synchronised pin events
  assign pulse_ev = q.sync2[PIN_PULSE] & ~q.prev_pulse;
  assign up = q.sync2[PIN_UP];
  assign di_lvl = q.sync2[PIN_DI];
  assign di_rise = di_lvl & ~q.prev_di;
  assign ti_rise = q.sync2[PIN_TI] & ~q.prev_ti;
  assign hw_ok = (q.di_fn != DI_HW_GATE) | di_lvl;
  assign gate_now = q.sw_open & hw_ok;
  assign gate_start = gate_now & ~q.gate;
  assign feed_now = (q.di_fn == DI_LATCH) ? q.latch : q.count;

  //============================================================================
  // Next state
  always_comb begin
    n = q;
    hit = 1'b0;
    load_ev = 1'b0;
    sw_new = q.sw_bit;
    sw_rise_wr = 1'b0;
    init_val = RST_ZERO;
    cmp_sel = q.cmp1;
    n.sync1 = {sample_instant_i, digital_input_i, count_up_i, count_pulse_i};
    n.sync2 = q.sync1;
    n.prev_pulse = q.sync2[PIN_PULSE];
    n.prev_di = q.sync2[PIN_DI];
    n.prev_ti = q.sync2[PIN_TI];

    if (wr_i && addr_i == OFS_CTRL) begin
      sw_new = wdata_i[CTRL_SW];
      n.out_plain = wdata_i[CTRL_OUT_LSB +: 2];
    end
    n.sw_bit = sw_new;
    sw_rise_wr = sw_new & ~q.sw_bit;
    if (sw_rise_wr) begin
      n.sw_open = 1'b1;
    end else if (!sw_new) begin
      n.sw_open = 1'b0;
    end
    n.gate = gate_now;

    if (gate_now && pulse_ev) begin
      n.count = up ? q.count + 32'h0000_0001 : q.count - 32'h0000_0001;
      if (q.mode != MODE_CONT) begin
        unique case (q.dir)
          DIR_NONE: hit = up ? (q.count == CNT_MAX) : (q.count == CNT_MIN);
          DIR_UP: hit = up && (n.count == q.hilim);
          DIR_DOWN: hit = !up && (n.count == RST_ZERO);
        endcase
      end
      if (hit) begin
        n.count = q.staged;
        if (q.mode == MODE_ONCE) begin
          n.sw_open = 1'b0;
        end
      end
    end

    if (gate_start && !q.gate_intr) begin
      load_ev = 1'b1;
    end
    if (di_rise && q.sw_open && (q.di_fn == DI_SYNC || q.di_fn == DI_LATCH)) begin
      load_ev = 1'b1;
    end
    if (di_rise && q.sw_open && q.di_fn == DI_LATCH) begin
      n.latch = q.count;
    end
    if (load_ev) begin
      n.count = q.staged;
    end

    if (wr_i) begin
      unique case (addr_i)
        OFS_DIRECT: n.count = wdata_i;
        OFS_STAGED: n.staged = wdata_i;
        OFS_CMP1: n.cmp1 = wdata_i;
        OFS_CMP2: n.cmp2 = wdata_i;
        OFS_HILIM: n.hilim = wdata_i;
        OFS_DOPAR: begin
          n.pulse_len = wdata_i[DOPAR_PLEN_LSB +: 16];
          n.hyst = wdata_i[DOPAR_HYST_LSB +: 16];
        end
        OFS_CFG: begin
          n.mode = (wdata_i[CFG_MODE_LSB +: 2] == 2'h3) ? MODE_CONT : mode_t'(wdata_i[CFG_MODE_LSB +: 2]);
          n.dir = (wdata_i[CFG_DIR_LSB +: 2] == 2'h3) ? DIR_NONE : dir_t'(wdata_i[CFG_DIR_LSB +: 2]);
          n.di_fn = di_fn_t'(wdata_i[CFG_DI_LSB +: 2]);
          n.gate_intr = wdata_i[CFG_GINT];
          n.do_fn[0] = fn_clean(wdata_i[CFG_DO0_LSB +: 3], 1'b1);
          n.do_fn[1] = fn_clean(wdata_i[CFG_DO1_LSB +: 3], 1'b0);
          init_val = (n.dir == DIR_DOWN) ? q.hilim : RST_ZERO;
          n.staged = init_val;
          n.count = init_val;
          n.cmp1 = init_val;
          n.cmp2 = init_val;
          n.latch = init_val;
        end
        default: ;
      endcase
    end

    for (int i = 0; i < 2; i++) begin
      cmp_sel = (i == 0) ? q.cmp1 : q.cmp2;
      if (n.count == cmp_sel && q.count != cmp_sel) begin
        n.ptime[i] = q.pulse_len;
      end else if (q.ptime[i] != 16'h0000) begin
        n.ptime[i] = q.ptime[i] - 16'h0001;
      end
      n.do_q[i] = out_level(q.do_fn[i], q.do_q[i], q.out_plain[i], q.count, cmp_sel, q.cmp2, q.hyst,
                            q.ptime[i] != 16'h0000);
    end

    if (ti_rise) begin
      n.snap_val = feed_now;
      n.snap_sts = {q.do_q, up, di_lvl, q.gate};
    end

    n.rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        OFS_CTRL: n.rdata = {29'h0000_0000, q.out_plain, q.sw_bit};
        OFS_DIRECT: n.rdata = q.count;
        OFS_STAGED: n.rdata = q.staged;
        OFS_CMP1: n.rdata = q.cmp1;
        OFS_CMP2: n.rdata = q.cmp2;
        OFS_HILIM: n.rdata = q.hilim;
        OFS_CFG: begin
          n.rdata[CFG_MODE_LSB +: 2] = q.mode;
          n.rdata[CFG_DIR_LSB +: 2] = q.dir;
          n.rdata[CFG_DI_LSB +: 2] = q.di_fn;
          n.rdata[CFG_GINT] = q.gate_intr;
          n.rdata[CFG_DO0_LSB +: 3] = q.do_fn[0];
          n.rdata[CFG_DO1_LSB +: 3] = q.do_fn[1];
        end
        OFS_DOPAR: n.rdata = {q.hyst, q.pulse_len};
        OFS_FEED: n.rdata = q.snap_val;
        OFS_STAT: n.rdata = {27'h000_0000, q.snap_sts};
        default: n.rdata = '0;
      endcase
    end
  end

  //============================================================================
  // Registers
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      q <= '0;
      q.hilim <= RST_HILIM;
    end else begin
      q <= n;
    end
  end

  assign rdata_o = q.rdata;
  assign first_digital_output_o = q.do_q[0];
  assign second_digital_output_o = q.do_q[1];
  assign gate_open_o = q.gate;

  //============================================================================
  // Checks
  sequence direct_wr_s;
    wr_i && addr_i == OFS_DIRECT;
  endsequence

  sequence cfg_down_s;
    wr_i && addr_i == OFS_CFG && wdata_i[CFG_DIR_LSB +: 2] == 2'h2;
  endsequence

  sequence quiet_step_s;
    gate_now && pulse_ev && !wr_i && !load_ev;
  endsequence

  sequence ti_s;
    ti_rise;
  endsequence

  AST_DIRECT_LOAD: assert property (@(posedge clock_i) disable iff (srst_i)
    direct_wr_s |=> q.count == $past(wdata_i))
    else $error("direct load not applied");

  AST_WRAP_UP: assert property (@(posedge clock_i) disable iff (srst_i)
    (quiet_step_s and (q.mode == MODE_CONT && up && q.count == CNT_MAX)) |=> q.count == CNT_MIN)
    else $error("up wrap wrong");

  AST_WRAP_DOWN: assert property (@(posedge clock_i) disable iff (srst_i)
    (quiet_step_s and (q.mode == MODE_CONT && !up && q.count == CNT_MIN)) |=> q.count == CNT_MAX)
    else $error("down wrap wrong");

  AST_STEP: assert property (@(posedge clock_i) disable iff (srst_i)
    (quiet_step_s and (q.mode == MODE_CONT && up)) |=> q.count == $past(q.count) + 32'h0000_0001)
    else $error("count step wrong");

  AST_ONCE_UP_CLOSE: assert property (@(posedge clock_i) disable iff (srst_i)
    (quiet_step_s and (q.mode == MODE_ONCE && q.dir == DIR_UP && up && q.count + 32'h0000_0001 == q.hilim))
    |=> (q.count == $past(q.staged) && !q.sw_open) ##1 !gate_open_o)
    else $error("once up closure wrong");

  AST_DOWN_ZERO: assert property (@(posedge clock_i) disable iff (srst_i)
    (quiet_step_s and (q.mode == MODE_PERIODIC && q.dir == DIR_DOWN && !up && q.count == 32'h0000_0001))
    |=> q.count == $past(q.staged) && q.sw_open == $past(q.sw_open))
    else $error("zero reload wrong");

  AST_INIT_DOWN: assert property (@(posedge clock_i) disable iff (srst_i)
    cfg_down_s |=> q.count == q.hilim && q.staged == q.hilim && q.latch == q.hilim && q.cmp2 == q.hilim)
    else $error("down initial values wrong");

  AST_GATE_AND: assert property (@(posedge clock_i) disable iff (srst_i)
    (!q.sw_open || (q.di_fn == DI_HW_GATE && !di_lvl)) |=> !gate_open_o)
    else $error("gate open without both gates");

  AST_SW_EDGE: assert property (@(posedge clock_i) disable iff (srst_i)
    $rose(q.sw_open) |-> $past(sw_rise_wr))
    else $error("gate opened without edge");

  AST_SNAPSHOT: assert property (@(posedge clock_i) disable iff (srst_i)
    ti_s |=> q.snap_val == $past(feed_now) ##1 q.snap_val == $past(q.snap_val) || $past(ti_rise))
    else $error("snapshot wrong");

  AST_READ_ONE: assert property (@(posedge clock_i) disable iff (srst_i)
    !rd_i |=> rdata_o == 32'h0000_0000)
    else $error("read data outside answer cycle");

  AST_CANCEL_LOAD: assert property (@(posedge clock_i) disable iff (srst_i)
    (gate_start && !q.gate_intr && !wr_i) |=> q.count == $past(q.staged))
    else $error("cancelling start did not load");

  // Resume must not touch the count
  AST_INTR_KEEP: assert property (@(posedge clock_i) disable iff (srst_i)
    (gate_start && q.gate_intr && !pulse_ev && !load_ev && !wr_i) |=> q.count == $past(q.count))
    else $error("interrupting start changed count");

  AST_LATCH_RETRIGGER: assert property (@(posedge clock_i) disable iff (srst_i)
    (di_rise && q.sw_open && q.di_fn == DI_LATCH && !wr_i)
    |=> q.latch == $past(q.count) && q.count == $past(q.staged))
    else $error("latch and retrigger wrong");

endmodule : pulse_counter_continuous_once
`default_nettype wire

// ===== verilog/pulse_counter_pkg.sv
// Package: register map, field layout, reset values and modes of the pulse counter
//==============================================================================
// Contract
// - Count is a signed 32-bit value spanning the full two's complement range.
// - Counting mode selects continuous, once-only or periodic behaviour.
// - Writing the direct load register replaces the count at once.
// - Once/periodic, no direction: staged value loads on a pulse past either range limit (overflow or underflow).
// - Once/periodic, direction up: staged value loads on reaching the high limit.
// - Once/periodic, direction down: staged value loads on reaching zero.
// - Staged value loads on gate start, sync and latch-retrigger, not on resume.
// - Main direction sets initial values and the reload limit; pulse direction always honoured.
// - Configuration write initialises values to zero, or high limit when down.
// - Every bus cycle is accepted and answered without waiting.
// - Feedback reports count or latch and status as at the sampling instant.
// - Pulses after the sampling instant appear in the following snapshot.
// - Continuous mode: up pulse at maximum wraps to minimum, pulse kept.
// - Continuous mode: down pulse at minimum wraps to maximum, pulse kept.
// - Digital input is plain input, hardware gate, latch or synchronisation.
// - Outputs: plain, at-or-above, at-or-below, pulse; window on first only.
// - Output switching is shaped by hysteresis and pulse duration.
// - Staged, count, comparison and output settings are writable while counting.
// - Once-only, no direction: full range, gate closes on overflow or underflow.
// - Once-only up: at high limit reload staged value and close gate.
// - Once-only down: low limit zero, load from high limit, close at zero.
// - After auto closure a new gate edge is needed; interrupting gate keeps count.
// - Counting runs only while software gate and hardware gate are both open.
// - Software gate opens on a rising control bit edge, closes when cleared.
// - Cancelling gate restarts from staged value; interrupting gate continues.
package pulse_counter_pkg;

  //============================================================================
  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIRECT = 8'h04;
  localparam logic [7:0] OFS_STAGED = 8'h08;
  localparam logic [7:0] OFS_CMP1 = 8'h0C;
  localparam logic [7:0] OFS_CMP2 = 8'h10;
  localparam logic [7:0] OFS_HILIM = 8'h14;
  localparam logic [7:0] OFS_CFG = 8'h18;
  localparam logic [7:0] OFS_DOPAR = 8'h1C;
  localparam logic [7:0] OFS_FEED = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h24;

  //============================================================================
  // Field positions
  localparam int CTRL_SW = 0;
  localparam int CTRL_OUT_LSB = 1;
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_DIR_LSB = 2;
  localparam int CFG_DI_LSB = 4;
  localparam int CFG_GINT = 6;
  localparam int CFG_DO0_LSB = 8;
  localparam int CFG_DO1_LSB = 12;
  localparam int DOPAR_PLEN_LSB = 0;
  localparam int DOPAR_HYST_LSB = 16;
  localparam int PIN_PULSE = 0;
  localparam int PIN_UP = 1;
  localparam int PIN_DI = 2;
  localparam int PIN_TI = 3;

  //============================================================================
  // Reset values and limits
  localparam logic [31:0] CNT_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] CNT_MIN = 32'h8000_0000;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_HILIM = 32'h7FFF_FFFF;

  //============================================================================
  // Modes
  typedef enum logic [1:0] {MODE_CONT = 2'b00, MODE_ONCE = 2'b01, MODE_PERIODIC = 2'b10} mode_t;
  typedef enum logic [1:0] {DIR_NONE = 2'b00, DIR_UP = 2'b01, DIR_DOWN = 2'b10} dir_t;
  typedef enum logic [1:0] {DI_INPUT = 2'b00, DI_HW_GATE = 2'b01, DI_LATCH = 2'b10, DI_SYNC = 2'b11} di_fn_t;
  typedef enum logic [2:0] {
    DO_PLAIN = 3'b000,
    DO_GE = 3'b001,
    DO_LE = 3'b010,
    DO_PULSE = 3'b011,
    DO_WINDOW = 3'b100
  } do_fn_t;

endpackage : pulse_counter_pkg

// ===== sim/pulse_source_model.sv
// Encoder model: one count pulse per request, direction pin set up first
`timescale 1ns/1ps
`default_nettype none
module pulse_source_model (
  // Clock
  input wire logic clock_i,
  // Request from the bench
  input wire logic fire_i,
  input wire logic up_i,
  input wire logic [3:0] hold_i,
  // Encoder pins
  output logic pulse_o,
  output logic dir_o,
  output logic busy_o
);
  //============================================================================
  // Phase sequencer
  // Phases 1 to 3 each last hold cycles; below 3 the synchroniser may miss edges
  logic [1:0] phase = 2'd0;
  logic [3:0] left = 4'h0;
  logic [3:0] hold = 4'h3;
  initial pulse_o = 1'b0;
  initial dir_o = 1'b0;
  assign busy_o = (phase != 2'd0);
  always @(posedge clock_i) begin
    if (phase == 2'd0) begin
      if (fire_i) begin
        dir_o <= up_i;
        hold <= hold_i;
        left <= hold_i;
        phase <= 2'd1;
      end
    end else if (left > 4'h1) begin
      left <= left - 4'h1;
    end else begin
      left <= hold;
      pulse_o <= (phase == 2'd1);
      phase <= (phase == 2'd3) ? 2'd0 : phase + 2'd1;
    end
  end
endmodule : pulse_source_model
`default_nettype wire

// ===== sim/tb_pulse_counter_continuous_once.sv
// Testbench: pulse counter core with encoder model and register master
`timescale 1ns/1ps
`default_nettype none
module tb_pulse_counter_continuous_once;
  import pulse_counter_pkg::*;
  logic clock_i = 1'b0;
  logic srst_i = 1'b1;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000;
  logic digital_input_i = 1'b0;
  logic sample_instant_i = 1'b0;
  logic fire = 1'b0;
  logic up = 1'b0;
  logic [3:0] hold = 4'h3;
  logic pulse, dir, busy, out1, out2, gate, rd_seen;
  logic [31:0] rdata_o, v, s;
  logic [31:0] exp_q[$];
  int error_cnt = 0;
  int n_checks = 0;
  always #2.5 clock_i = ~clock_i;

  pulse_counter_continuous_once i_pulse_counter_continuous_once (
    .clock_i(clock_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .count_pulse_i(pulse),
    .count_up_i(dir), .digital_input_i(digital_input_i), .sample_instant_i(sample_instant_i),
    .first_digital_output_o(out1), .second_digital_output_o(out2), .gate_open_o(gate));
  pulse_source_model i_pulse_source_model (
    .clock_i(clock_i), .fire_i(fire), .up_i(up), .hold_i(hold),
    .pulse_o(pulse), .dir_o(dir), .busy_o(busy));

  //============================================================================
  // Compare and report
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_pin(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_pin
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // Read data stands only in the cycle after the strobe
  initial rd_seen = 1'b0;
  always @(posedge clock_i) begin
    if (rd_seen) begin
      cmp_word(rdata_o, (exp_q.size() > 0) ? exp_q.pop_front() : ~rdata_o);
    end
    rd_seen <= rd_i;
  end

  //============================================================================
  // Bus and pin tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
  endtask : rd
  task automatic pulses(input int n, input logic u);
    for (int i = 0; i < n; i++) begin
      @(posedge clock_i);
      fire <= 1'b1;
      up <= u;
      hold <= 4'(3 + $urandom % 3);
      @(posedge clock_i);
      fire <= 1'b0;
      for (int k = 0; k < 60; k++) begin
        @(posedge clock_i);
        #1;
        if (!busy) break;
      end
    end
    repeat (3) @(posedge clock_i);
  endtask : pulses
  task automatic gate_is(input logic e);
    repeat (5) @(posedge clock_i);
    cmp_pin(gate, e);
  endtask : gate_is
  task automatic done(input string name);
    repeat (3) @(posedge clock_i);
    $display("test %s done", name);
  endtask : done

  //============================================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock_i);
    error_cnt++;
    final_report();
  end

  //============================================================================
  // Scenarios
  initial begin
    void'($urandom(97112));
    repeat (8) @(posedge clock_i);
    srst_i <= 1'b0;
    rd(OFS_HILIM, RST_HILIM);
    rd(OFS_DIRECT, RST_ZERO);
    rd(8'h3C, 32'h0000_0000);
    done("reset");
    v = $urandom;
    s = $urandom;
    wr(OFS_DIRECT, v);
    rd(OFS_DIRECT, v);
    wr(OFS_STAGED, s);
    wr(OFS_CTRL, 32'h0000_0001);
    gate_is(1'b1);
    rd(OFS_DIRECT, s);
    pulses(3, 1'b1);
    pulses(1, 1'b0);
    rd(OFS_DIRECT, s + 32'h0000_0002);
    sample_instant_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    sample_instant_i <= 1'b0;
    pulses(2, 1'b1);
    rd(OFS_FEED, s + 32'h0000_0002);
    rd(OFS_DIRECT, s + 32'h0000_0004);
    done("gate start and snapshot");
    wr(OFS_DIRECT, CNT_MAX);
    pulses(1, 1'b1);
    rd(OFS_DIRECT, CNT_MIN);
    pulses(1, 1'b0);
    rd(OFS_DIRECT, CNT_MAX);
    wr(OFS_CTRL, 32'h0000_0000);
    gate_is(1'b0);
    pulses(1, 1'b1);
    rd(OFS_DIRECT, CNT_MAX);
    wr(OFS_CTRL, 32'h0000_0005);
    rd(OFS_DIRECT, s);
    cmp_pin(out2, 1'b1);
    cmp_pin(out1, 1'b0);
    done("wrap and cancel");
    wr(OFS_CFG, 32'h0000_0010);
    gate_is(1'b0);
    digital_input_i <= 1'b1;
    gate_is(1'b1);
    pulses(1, 1'b1);
    rd(OFS_DIRECT, 32'h0000_0001);
    digital_input_i <= 1'b0;
    gate_is(1'b0);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CFG, 32'h0000_2100);
    wr(OFS_CMP1, 32'h0000_000A);
    wr(OFS_CMP2, 32'h0000_0009);
    wr(OFS_STAGED, 32'h0000_0009);
    wr(OFS_DOPAR, 32'h0001_0000);
    rd(OFS_CFG, 32'h0000_2100);
    rd(OFS_DOPAR, 32'h0001_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    gate_is(1'b1);
    cmp_pin(out1, 1'b0);
    cmp_pin(out2, 1'b1);
    pulses(1, 1'b1);
    cmp_pin(out1, 1'b1);
    cmp_pin(out2, 1'b1);
    pulses(1, 1'b0);
    cmp_pin(out1, 1'b1);
    pulses(1, 1'b0);
    cmp_pin(out1, 1'b0);
    pulses(3, 1'b1);
    cmp_pin(out2, 1'b0);
    wr(OFS_CTRL, 32'h0000_0000);
    done("hardware gate and output");
    wr(OFS_HILIM, 32'h0000_0003);
    wr(OFS_CFG, 32'h0000_0005);
    rd(OFS_STAGED, 32'h0000_0000);
    wr(OFS_STAGED, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0001);
    pulses(2, 1'b1);
    gate_is(1'b0);
    rd(OFS_DIRECT, 32'h0000_0001);
    pulses(1, 1'b1);
    rd(OFS_DIRECT, 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    gate_is(1'b1);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_HILIM, 32'h0000_0004);
    wr(OFS_CFG, 32'h0000_0009);
    rd(OFS_CMP1, 32'h0000_0004);
    rd(OFS_DIRECT, 32'h0000_0004);
    wr(OFS_CTRL, 32'h0000_0001);
    pulses(4, 1'b0);
    gate_is(1'b0);
    rd(OFS_DIRECT, 32'h0000_0004);
    done("once up and down");
    wr(OFS_CFG, 32'h0000_0001);
    wr(OFS_STAGED, CNT_MAX - 32'h0000_0001);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    pulses(2, 1'b1);
    gate_is(1'b0);
    rd(OFS_DIRECT, CNT_MAX - 32'h0000_0001);
    wr(OFS_HILIM, 32'h0000_0002);
    wr(OFS_CFG, 32'h0000_0006);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    pulses(2, 1'b1);
    gate_is(1'b1);
    rd(OFS_DIRECT, 32'h0000_0000);
    wr(OFS_CFG, 32'h0000_000A);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    pulses(2, 1'b0);
    gate_is(1'b1);
    rd(OFS_DIRECT, 32'h0000_0002);
    done("once none and periodic");
    wr(OFS_CFG, 32'h0000_0420);
    wr(OFS_STAGED, 32'h0000_0005);
    cmp_pin(out1, 1'b1);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    pulses(2, 1'b1);
    digital_input_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    sample_instant_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    sample_instant_i <= 1'b0;
    digital_input_i <= 1'b0;
    rd(OFS_FEED, 32'h0000_0007);
    rd(OFS_STAT, 32'h0000_0007);
    rd(OFS_DIRECT, 32'h0000_0005);
    cmp_pin(out1, 1'b0);
    done("latch and window");
    wr(OFS_CFG, 32'h0000_0040);
    wr(OFS_STAGED, 32'h0000_0009);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    pulses(1, 1'b1);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0001);
    rd(OFS_DIRECT, 32'h0000_0001);
    done("interrupting gate");
    srst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    rd(OFS_HILIM, RST_HILIM);
    rd(OFS_CFG, 32'h0000_0000);
    cmp_pin(gate, 1'b0);
    done("mid-run reset");
    repeat (10) @(posedge clock_i);
    final_report();
  end
endmodule : tb_pulse_counter_continuous_once
`default_nettype wire
